/* File: hw/t2cto_pkg.sv */
// Operation
// RQ1: overflow flag sticky, cleared only by software
// RQ2: no overflow flag while baud or clock-out
// RQ3: external flag set on triggered capture/reload
// RQ4: 16-bit count of ticks or external events
// RQ5: capture on falling edge when enabled
// RQ6: reload on overflow or falling edge
// RQ7: baud mode always auto-reloads on overflow
// RQ8: basic timer overflow inverts its toggle output
// RQ9: enable bit picks port data or toggle
// RQ10: toggle rate follows prescaler and reload values
// RQ11: overflow and underflow set flag, raise request
// RQ12: reload, capture and baud modes supported
// RQ13: capture without trigger runs as plain counter
// RQ14: falling edge copies count into capture registers
// RQ15: external flag raises request in capture mode
// RQ16: select bits route timer2 rate to uarts
// RQ17: run bit starts and stops timer2
// RQ18: mode decode follows the mode table
// RQ19: basic flag blocked while toggle output enabled
// RQ20: external flag sticky until software clears it; up/down mode toggles it in hardware on overflow or underflow
// RQ21: capture input synchronised, edges from samples
package t2cto_pkg;

  // ****************************************************************
  // register map, byte addresses on the apb bus
  // ****************************************************************
  localparam int unsigned T2CTO_ADDR_W = 12;
  localparam logic [11:0] OFS_CONTROL = 12'h418;
  localparam logic [11:0] OFS_COUNT = 12'h41C;
  localparam logic [11:0] OFS_CAPTURE = 12'h420;
  localparam logic [11:0] OFS_MODE_EXT = 12'h424;
  localparam logic [11:0] OFS_EXT_STATUS = 12'h428;
  localparam logic [11:0] OFS_BASIC_FLAGS = 12'h42C;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int unsigned BIT_T0_TOGGLE_EN = 0;
  localparam int unsigned BIT_T1_TOGGLE_EN = 2;

  // ****************************************************************
  // reset values and count limits
  // ****************************************************************
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_MODE_EXT = 8'h00;
  localparam logic [7:0] RST_EXT_STATUS = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] RST_CAPTURE = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // control register layout, msb first
  typedef struct packed {
    logic timer2_overflow_flag;
    logic timer2_external_edge_flag;
    logic uart0_receive_clock_select;
    logic uart0_transmit_clock_select;
    logic timer2_external_trigger_enable;
    logic timer2_run;
    logic timer2_counter_select;
    logic capture_reload_select;
  } t2cto_ctrl_type;

  // mode extension register layout, msb first
  typedef struct packed {
    logic [1:0] spare_hi;
    logic uart1_receive_clock_select;
    logic uart1_transmit_clock_select;
    logic [1:0] spare_lo;
    logic timer2_clock_out_enable;
    logic down_count_enable;
  } t2cto_mode_ext_type;

  // decoded operating mode
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_RELOAD_UP = 3'b001,
    MODE_RELOAD_UPDOWN = 3'b010,
    MODE_CAPTURE = 3'b011,
    MODE_BAUD = 3'b100
  } t2cto_mode_type;

endpackage

/* File: hw/t2cto_toggle.sv */
`timescale 1ns/1ns
// ******************************************************************
// overflow toggle outputs and flags of the basic timers
// ******************************************************************
module t2cto_toggle
  import t2cto_pkg::*;
#(
  parameter int unsigned CHANNELS = 2
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [CHANNELS-1:0] overflow_in,
  input wire logic [CHANNELS-1:0] toggle_enable,
  input wire logic [CHANNELS-1:0] port_data,
  input wire logic [CHANNELS-1:0] port_drive,
  input wire logic flag_write,
  input wire logic [CHANNELS-1:0] flag_wdata,
  output logic [CHANNELS-1:0] pin_out,
  output logic [CHANNELS-1:0] pin_oe,
  output logic [CHANNELS-1:0] overflow_flag
);

  // refuse an empty channel set
  if (CHANNELS < 1)
  begin : g_bad
    $error("t2cto_toggle needs at least one channel");
  end

  for (genvar i = 0; i < CHANNELS; i++)
  begin : g_chan
    logic toggle_reg; // level inverted on each overflow

    // toggle flop, one inversion per overflow
    // RQ8: invert on overflow
    // RQ10: rate set by overflow period
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        toggle_reg <= 1'b0;
      else if (clk_en && overflow_in[i])
        toggle_reg <= ~toggle_reg;
    end

    // pin drive, port latch or toggle level
    // RQ9: select pin source
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
      begin
        pin_out[i] <= 1'b0;
        pin_oe[i] <= 1'b0;
      end
      else if (clk_en)
      begin
        pin_out[i] <= toggle_enable[i] ? toggle_reg : port_data[i];
        pin_oe[i] <= toggle_enable[i] | port_drive[i];
      end
    end

    // overflow flag, set wins over software clear
    // RQ19: blocked by toggle enable
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        overflow_flag[i] <= 1'b0;
      else if (clk_en)
      begin
        if (overflow_in[i] && !toggle_enable[i])
          overflow_flag[i] <= 1'b1;
        else if (flag_write)
          overflow_flag[i] <= flag_wdata[i];
      end
    end

    AST_TOGGLE_INVERT: assert property ( // RQ8
      @(posedge clk_sys) disable iff (!rst_n)
      (clk_en && overflow_in[i]) |=> (toggle_reg != $past(toggle_reg)))
      else $error("toggle level did not invert on overflow");

    AST_FLAG_BLOCKED: assert property ( // RQ19
      @(posedge clk_sys) disable iff (!rst_n)
      (toggle_enable[i] && !overflow_flag[i] && !flag_write) |=> !overflow_flag[i])
      else $error("basic flag set while toggle output enabled");
  end

endmodule

/* File: hw/t2cto_top.sv */
`timescale 1ns/1ns
// ******************************************************************
// timer2 with capture, reload, baud ticks and toggle outputs
// ******************************************************************
module t2cto_top
  import t2cto_pkg::*;
#(
  parameter int unsigned ADDR_W = T2CTO_ADDR_W
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic timer_tick,
  input wire logic timer2_count_in,
  input wire logic capture_reload_input,
  input wire logic timer0_overflow_in,
  input wire logic timer1_overflow_in,
  input wire logic [1:0] port_latch_data,
  input wire logic [1:0] port_drive_en,
  output logic [1:0] toggle_pin_out,
  output logic [1:0] toggle_pin_oe,
  output logic uart0_rx_clk_tick,
  output logic uart0_tx_clk_tick,
  output logic uart1_rx_clk_tick,
  output logic uart1_tx_clk_tick,
  output logic timer2_irq
);

  // the map needs twelve address bits
  if (ADDR_W < T2CTO_ADDR_W)
  begin : g_bad_addr
    $error("t2cto_top address bus too narrow");
  end

  // ****************************************************************
  // declarations
  // ****************************************************************
  t2cto_ctrl_type ctrl_reg; // control register
  t2cto_ctrl_type ctrl_next; // control register next value
  t2cto_mode_ext_type mode_reg; // mode extension register
  logic [7:0] ext_status_reg; // toggle output enables
  logic [15:0] count_reg; // timer2 count
  logic [15:0] count_next; // count next value
  logic [15:0] capture_reg; // capture / reload value
  logic ex_meta_reg; // capture input first stage
  logic ex_sync_reg; // capture input synchronised
  logic ex_prev_reg; // previous synchronised sample
  logic cnt_meta_reg; // count input first stage
  logic cnt_sync_reg; // count input synchronised
  logic cnt_prev_reg; // previous count sample
  logic pready_reg; // apb answer
  logic [31:0] prdata_reg; // apb read data
  logic pslverr_reg; // apb error
  logic irq_reg; // timer2 interrupt request
  logic [3:0] tick_reg; // uart baud ticks
  logic [1:0] basic_flags; // basic timer overflow flags
  t2cto_mode_type cur_mode; // decoded mode
  logic baud_any; // any uart select bit set
  logic ext_fall; // falling edge on capture input
  logic cnt_fall; // falling edge on count input
  logic step; // count one this cycle
  logic ovf_evt; // overflow this cycle
  logic unf_evt; // underflow this cycle
  logic capture_now; // capture this cycle
  logic ext_evt; // external trigger acted
  logic exf_toggle; // flag toggle in up/down mode
  logic tf2_set; // overflow flag set request
  logic exf_base; // flag before hardware update
  logic commit; // apb write takes effect
  logic [31:0] rd_mux; // read data selection
  logic rd_hit; // address is mapped
  logic wr_ctrl; // write control register
  logic wr_count; // write count register
  logic wr_capture; // write capture register
  logic wr_mode; // write mode extension
  logic wr_status; // write extended status
  logic wr_flags; // write basic flags

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************

  // two flops per pin, then one more for the edge compare
  // RQ21: synchronise and compare
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ex_meta_reg <= 1'b1;
      ex_sync_reg <= 1'b1;
      ex_prev_reg <= 1'b1;
      cnt_meta_reg <= 1'b1;
      cnt_sync_reg <= 1'b1;
      cnt_prev_reg <= 1'b1;
    end
    else if (clk_en)
    begin
      ex_meta_reg <= capture_reload_input;
      ex_sync_reg <= ex_meta_reg;
      ex_prev_reg <= ex_sync_reg;
      cnt_meta_reg <= timer2_count_in;
      cnt_sync_reg <= cnt_meta_reg;
      cnt_prev_reg <= cnt_sync_reg;
    end
  end

  assign ext_fall = ex_prev_reg & ~ex_sync_reg;
  assign cnt_fall = cnt_prev_reg & ~cnt_sync_reg;

  // ****************************************************************
  // mode decode
  // ****************************************************************
  assign baud_any = ctrl_reg.uart0_receive_clock_select
    | ctrl_reg.uart0_transmit_clock_select
    | mode_reg.uart1_receive_clock_select
    | mode_reg.uart1_transmit_clock_select;

  // table decode, baud selects override capture select
  // RQ18: mode table
  // RQ12: three modes
  always_comb
  begin
    if (!ctrl_reg.timer2_run)
      cur_mode = MODE_OFF;
    else if (baud_any)
      cur_mode = MODE_BAUD;
    else if (ctrl_reg.capture_reload_select)
      cur_mode = MODE_CAPTURE;
    else if (mode_reg.down_count_enable)
      cur_mode = MODE_RELOAD_UPDOWN;
    else
      cur_mode = MODE_RELOAD_UP;
  end

  // count source, prescaled tick or external events
  // RQ4: timer or counter
  // RQ17: run gates counting
  assign step = ctrl_reg.timer2_run
    & (ctrl_reg.timer2_counter_select ? cnt_fall : timer_tick);

  // ****************************************************************
  // counter datapath
  // ****************************************************************

  // next count and events for the current mode
  always_comb
  begin
    count_next = count_reg;
    ovf_evt = 1'b0;
    unf_evt = 1'b0;
    capture_now = 1'b0;
    ext_evt = 1'b0;
    exf_toggle = 1'b0;
    case (cur_mode)
      // RQ7: baud always reloads
      MODE_BAUD:
      begin
        if (step)
        begin
          ovf_evt = (count_reg == COUNT_MAX);
          count_next = ovf_evt ? capture_reg : count_reg + 16'h0001;
        end
      end
      // RQ13: plain wrap counter
      // RQ5: capture on edge
      MODE_CAPTURE:
      begin
        if (step)
        begin
          ovf_evt = (count_reg == COUNT_MAX);
          count_next = count_reg + 16'h0001;
        end
        if (ctrl_reg.timer2_external_trigger_enable && ext_fall)
        begin
          capture_now = 1'b1;
          ext_evt = 1'b1;
        end
      end
      // RQ6: reload on overflow or edge
      MODE_RELOAD_UP:
      begin
        if (ctrl_reg.timer2_external_trigger_enable && ext_fall)
        begin
          count_next = capture_reg;
          ext_evt = 1'b1;
        end
        else if (step)
        begin
          ovf_evt = (count_reg == COUNT_MAX);
          count_next = ovf_evt ? capture_reg : count_reg + 16'h0001;
        end
      end
      // direction from capture input level
      // RQ11: underflow too
      MODE_RELOAD_UPDOWN:
      begin
        if (step)
        begin
          if (ex_sync_reg)
          begin
            ovf_evt = (count_reg == COUNT_MAX);
            count_next = ovf_evt ? capture_reg : count_reg + 16'h0001;
          end
          else
          begin
            unf_evt = (count_reg == capture_reg);
            count_next = unf_evt ? COUNT_MAX : count_reg - 16'h0001;
          end
        end
        exf_toggle = ovf_evt | unf_evt;
      end
      MODE_OFF:
      begin
        count_next = count_reg;
      end
      default:
      begin
        count_next = count_reg;
      end
    endcase
  end

  // suppress flag while timer2 feeds uarts or clock-out
  // RQ2: baud blocks flag
  // RQ11: overflow or underflow
  assign tf2_set = (ovf_evt | unf_evt) & ~baud_any
    & ~mode_reg.timer2_clock_out_enable;

  // count register, software write wins over counting
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      count_reg <= RST_COUNT;
    else if (clk_en)
    begin
      if (wr_count)
        count_reg <= pwdata[15:0];
      else
        count_reg <= count_next;
    end
  end

  // capture register, low and high bytes together
  // RQ14: copy count bytes
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      capture_reg <= RST_CAPTURE;
    else if (clk_en)
    begin
      if (wr_capture)
        capture_reg <= pwdata[15:0];
      else if (capture_now)
        capture_reg <= count_reg;
    end
  end

  // ****************************************************************
  // control register and flags
  // ****************************************************************

  // hardware sets win over a software clear in the same cycle
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl)
      ctrl_next = t2cto_ctrl_type'(pwdata[7:0]);
    exf_base = ctrl_next.timer2_external_edge_flag;
    // RQ1: set only, software clears
    if (tf2_set)
      ctrl_next.timer2_overflow_flag = 1'b1;
    // RQ3: set on triggered edge
    // RQ20: no hardware clear except the up/down toggle
    if (ext_evt)
      ctrl_next.timer2_external_edge_flag = 1'b1;
    else if (exf_toggle)
      ctrl_next.timer2_external_edge_flag = ~exf_base;
  end

  // control register update
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_reg <= t2cto_ctrl_type'(RST_CONTROL);
    else if (clk_en)
      ctrl_reg <= ctrl_next;
  end

  // mode extension and toggle enable registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_reg <= t2cto_mode_ext_type'(RST_MODE_EXT);
      ext_status_reg <= RST_EXT_STATUS;
    end
    else if (clk_en)
    begin
      if (wr_mode)
        mode_reg <= t2cto_mode_ext_type'(pwdata[7:0] & 8'h33);
      if (wr_status)
        ext_status_reg <= pwdata[7:0] & 8'h05;
    end
  end

  // ****************************************************************
  // interrupt request and uart baud ticks
  // ****************************************************************

  // request from either flag; edge flag silent in up/down mode
  // RQ15: edge flag interrupts
  // RQ11: flag as request
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      irq_reg <= 1'b0;
    else if (clk_en)
      irq_reg <= ctrl_reg.timer2_overflow_flag
        | (ctrl_reg.timer2_external_edge_flag & (cur_mode != MODE_RELOAD_UPDOWN));
  end

  // each select moves a uart from timer1 to timer2 rate
  // RQ16: baud source select
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      tick_reg <= 4'h0;
    else if (clk_en)
    begin
      tick_reg[0] <= ctrl_reg.uart0_receive_clock_select ? ovf_evt : timer1_overflow_in;
      tick_reg[1] <= ctrl_reg.uart0_transmit_clock_select ? ovf_evt : timer1_overflow_in;
      tick_reg[2] <= mode_reg.uart1_receive_clock_select ? ovf_evt : timer1_overflow_in;
      tick_reg[3] <= mode_reg.uart1_transmit_clock_select ? ovf_evt : timer1_overflow_in;
    end
  end

  // ****************************************************************
  // basic timer toggle outputs
  // ****************************************************************
  t2cto_toggle #(
    .CHANNELS(2)
  ) u_toggle (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .overflow_in({timer1_overflow_in, timer0_overflow_in}),
    .toggle_enable({ext_status_reg[BIT_T1_TOGGLE_EN], ext_status_reg[BIT_T0_TOGGLE_EN]}),
    .port_data(port_latch_data),
    .port_drive(port_drive_en),
    .flag_write(wr_flags),
    .flag_wdata(pwdata[1:0]),
    .pin_out(toggle_pin_out),
    .pin_oe(toggle_pin_oe),
    .overflow_flag(basic_flags)
  );

  // ****************************************************************
  // apb slave, one wait state, write at the completing edge
  // ****************************************************************
  assign commit = clk_en & psel & penable & pready_reg & pwrite & rd_hit;
  assign wr_ctrl = commit & (paddr[11:0] == OFS_CONTROL);
  assign wr_count = commit & (paddr[11:0] == OFS_COUNT);
  assign wr_capture = commit & (paddr[11:0] == OFS_CAPTURE);
  assign wr_mode = commit & (paddr[11:0] == OFS_MODE_EXT);
  assign wr_status = commit & (paddr[11:0] == OFS_EXT_STATUS);
  assign wr_flags = commit & (paddr[11:0] == OFS_BASIC_FLAGS);

  // read selection, unmapped answers zero with error
  always_comb
  begin
    rd_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    if ((paddr >> 12) != '0)
      rd_hit = 1'b0;
    else
    begin
      case (paddr[11:0])
        OFS_CONTROL: rd_mux[7:0] = ctrl_reg;
        OFS_COUNT: rd_mux[15:0] = count_reg;
        OFS_CAPTURE: rd_mux[15:0] = capture_reg;
        OFS_MODE_EXT: rd_mux[7:0] = mode_reg;
        OFS_EXT_STATUS: rd_mux[7:0] = ext_status_reg;
        OFS_BASIC_FLAGS: rd_mux[1:0] = basic_flags;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // answer one cycle into the access phase
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (psel && penable && !pready_reg)
      begin
        pready_reg <= 1'b1;
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_reg <= ~rd_hit;
      end
      else
      begin
        pready_reg <= 1'b0;
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  assign timer2_irq = irq_reg;
  assign uart0_rx_clk_tick = tick_reg[0];
  assign uart0_tx_clk_tick = tick_reg[1];
  assign uart1_rx_clk_tick = tick_reg[2];
  assign uart1_tx_clk_tick = tick_reg[3];

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_TF2_STICKY: assert property ( // RQ1
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(ctrl_reg.timer2_overflow_flag) |-> $past(wr_ctrl))
    else $error("overflow flag cleared without a write");

  AST_TF2_BLOCKED: assert property ( // RQ2
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && baud_any && !wr_ctrl && !ctrl_reg.timer2_overflow_flag)
      |=> !ctrl_reg.timer2_overflow_flag)
    else $error("overflow flag set in baud mode");

  AST_TIMER2_EXTERNAL_EDGE_FLAG_SET: assert property ( // RQ3
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && ext_fall && ctrl_reg.timer2_external_trigger_enable
      && (cur_mode == MODE_CAPTURE || cur_mode == MODE_RELOAD_UP))
      |=> ctrl_reg.timer2_external_edge_flag)
    else $error("external flag not set on edge");

  AST_CAPTURE: assert property ( // RQ14
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && capture_now && !wr_capture) |=> (capture_reg == $past(count_reg)))
    else $error("capture value wrong");

  AST_EDGE_RELOAD: assert property ( // RQ6
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && cur_mode == MODE_RELOAD_UP && ext_fall
      && ctrl_reg.timer2_external_trigger_enable && !wr_count)
      |=> (count_reg == $past(capture_reg)))
    else $error("edge reload missing");

  AST_BAUD_RELOAD: assert property ( // RQ7
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && cur_mode == MODE_BAUD && step && count_reg == COUNT_MAX && !wr_count)
      |=> (count_reg == $past(capture_reg)))
    else $error("baud overflow did not reload");

  AST_STOPPED: assert property ( // RQ17
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !ctrl_reg.timer2_run && !wr_count) |=> $stable(count_reg))
    else $error("count moved while stopped");

  AST_TIMER2_EXTERNAL_EDGE_FLAG_STICKY: assert property ( // RQ20
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(ctrl_reg.timer2_external_edge_flag) |-> ($past(wr_ctrl) || $past(exf_toggle)))
    else $error("external flag cleared by hardware");

  AST_UART_TICK: assert property ( // RQ16
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && ctrl_reg.uart0_receive_clock_select && ovf_evt) |=> uart0_rx_clk_tick)
    else $error("uart0 receive tick missing");

endmodule

/* File: dv/t2cto_pins.sv */
`timescale 1ns/1ns
// far side: capture pin, event pin and basic timer overflow pulses
module t2cto_pins
(
  input wire logic clk_sys,
  output logic cap_pin,
  output logic evt_pin,
  output logic [1:0] ovf
);
  // pins idle high, no pulses
  initial
  begin
    cap_pin = 1'b1;
    evt_pin = 1'b1;
    ovf = 2'b00;
  end
  // falling edge on the capture pin, held low long enough to sync
  task fall_cap();
    @(posedge clk_sys) cap_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    cap_pin <= 1'b1;
  endtask
  // falling edge on the event pin, held low long enough to sync
  task fall_evt();
    @(posedge clk_sys) evt_pin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    evt_pin <= 1'b1;
  endtask
  // one-cycle overflow pulse from basic timer k
  task pulse(input int k);
    @(posedge clk_sys) ovf[k] <= 1'b1;
    @(posedge clk_sys) ovf[k] <= 1'b0;
  endtask
endmodule

/* File: dv/timer2_capture_and_toggle_out_test.sv */
`timescale 1ns/1ns
module timer2_capture_and_toggle_out_test import t2cto_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic timer_tick = 1'b0;
  logic clk_en = 1'b1;
  logic pready, pslverr, irq, u0r, cap, evt, erv;
  logic [31:0] prdata, rdv;
  logic [1:0] tpo, toe, ovf;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_u0 = 0;
  always #20 clk_sys = ~clk_sys;
  // count uart0 receive ticks
  always @(posedge clk_sys) if (u0r === 1'b1) n_u0++;
  t2cto_top t2cto_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .timer_tick(timer_tick),
    .timer2_count_in(evt), .capture_reload_input(cap), .timer0_overflow_in(ovf[0]),
    .timer1_overflow_in(ovf[1]), .port_latch_data(2'b10), .port_drive_en(2'b00),
    .toggle_pin_out(tpo), .toggle_pin_oe(toe), .uart0_rx_clk_tick(u0r),
    .uart0_tx_clk_tick(), .uart1_rx_clk_tick(), .uart1_tx_clk_tick(), .timer2_irq(irq));
  t2cto_pins t2cto_pins_inst (.clk_sys(clk_sys), .cap_pin(cap), .evt_pin(evt), .ovf(ovf));
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    bit done;
    done = 1'b0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // answer taken at the rising edge that samples pready high
    for (i = 0; i < 20 && !done; i++)
    begin
      @(posedge clk_sys);
      done = (pready === 1'b1);
    end
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (!done)
    begin
      chk(32'h00000000, 32'h00000001);
      finish_test();
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(rdv, e);
  endtask
  // single prescaled tick, then let the result settle
  task tick();
    @(posedge clk_sys) timer_tick <= 1'b1;
    @(posedge clk_sys) timer_tick <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  // control register reset value and an unmapped read
  task t_reset();
    rd(OFS_CONTROL, 32'h00000000);
    rd(12'h400, 32'h00000000);
    chk(32'(erv), 32'h00000001);
    $display("done reset");
  endtask
  // rollover sets a sticky flag, software clears it
  task t_ovf();
    wr(OFS_COUNT, 32'h0000FFFF);
    wr(OFS_CONTROL, 32'h00000004);
    clk_en <= 1'b0;
    tick();
    clk_en <= 1'b1;
    rd(OFS_COUNT, 32'h0000FFFF);
    tick();
    rd(OFS_CONTROL, 32'h00000084);
    repeat (20) @(posedge clk_sys);
    rd(OFS_CONTROL, 32'h00000084);
    chk(32'(irq), 32'h00000001);
    rd(OFS_COUNT, 32'h00000000);
    wr(OFS_CONTROL, 32'h00000000);
    rd(OFS_CONTROL, 32'h00000000);
    chk(32'(irq), 32'h00000000);
    $display("done overflow");
  endtask
  // baud mode: no flag, reload and uart tick
  task t_baud();
    wr(OFS_CAPTURE, 32'h00001111);
    wr(OFS_COUNT, 32'h0000FFFF);
    n_u0 = 0;
    wr(OFS_CONTROL, 32'h00000025);
    tick();
    rd(OFS_CONTROL, 32'h00000025);
    rd(OFS_COUNT, 32'h00001111);
    chk(32'(n_u0), 32'h00000001);
    wr(OFS_CONTROL, 32'h00000000);
    $display("done baud");
  endtask
  // capture on falling edge of the capture pin
  task t_capture();
    wr(OFS_COUNT, 32'h00001234);
    wr(OFS_CONTROL, 32'h0000000D);
    t2cto_pins_inst.fall_cap();
    rd(OFS_CAPTURE, 32'h00001234);
    rd(OFS_CONTROL, 32'h0000004D);
    chk(32'(irq), 32'h00000001);
    wr(OFS_CONTROL, 32'h00000000);
    $display("done capture");
  endtask
  // counter mode counts event pin edges; capture pin edge reloads
  task t_reload();
    wr(OFS_COUNT, 32'h00000010);
    wr(OFS_CONTROL, 32'h0000000E);
    t2cto_pins_inst.fall_evt();
    rd(OFS_COUNT, 32'h00000011);
    t2cto_pins_inst.fall_cap();
    rd(OFS_COUNT, 32'h00001234);
    rd(OFS_CONTROL, 32'h0000004E);
    wr(OFS_CONTROL, 32'h00000000);
    $display("done reload");
  endtask
  // toggle output on basic timer overflow
  task t_toggle();
    wr(OFS_EXT_STATUS, 32'h00000001);
    t2cto_pins_inst.pulse(0);
    repeat (3) @(posedge clk_sys);
    chk(32'(toe), 32'h00000001);
    chk(32'(tpo), 32'h00000003);
    t2cto_pins_inst.pulse(0);
    t2cto_pins_inst.pulse(1);
    repeat (3) @(posedge clk_sys);
    chk(32'(tpo), 32'h00000002);
    rd(OFS_BASIC_FLAGS, 32'h00000002);
    $display("done toggle");
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_ovf();
    t_baud();
    t_capture();
    t_reload();
    t_toggle();
    finish_test();
  end
endmodule
